// file: emm_block_count.sv
// Purpose: totals the emulation blocks held by the map entries
// Assumes: overlapping entries are each counted in full
// Notes:   purely combinational
`default_nettype none

module emm_block_count
  import emm_pkg::*;
#(
  parameter int NENT = 8,
  parameter int BW   = 20,
  parameter int CW   = 24
) (
  emm_tab_if.user            tab,
  output logic [CW-1:0]      o_used
);

  logic [CW-1:0] span [NENT];

  genvar g;
  generate
    for (g = 0; g < NENT; g++) begin : g_span
      // target and guarded entries take no emulation memory
      assign span[g] = (tab.valid[g] && emm_is_emu(tab.desc[g])) ?
                       CW'(tab.last_blk[g]) - CW'(tab.first_blk[g]) + CW'(1) :
                       '0;
    end
  endgenerate

  always_comb begin
    o_used = '0;
    for (int i = 0; i < NENT; i++) begin
      o_used = o_used + span[i];
    end
  end

endmodule : emm_block_count

`default_nettype wire

// file: emm_cpu_model.sv
// Purpose: emulation processor issuing memory cycles
// Assumes: one address per cycle, driven after the rising edge
// Notes:   idle bus shows the inverted last address
`default_nettype none

module emm_cpu_model (
  input  wire logic        i_clk,
  output logic      [31:0] o_addr,
  output logic             o_cyc,
  output logic             o_wr
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_addr = 32'h0;
    o_cyc  = 1'b0;
    o_wr   = 1'b0;
  end

  task automatic cyc(input logic [31:0] a, input logic w);
    @(posedge i_clk);
    o_addr <= a;
    o_cyc  <= 1'b1;
    o_wr   <= w;
    @(posedge i_clk);
    o_cyc  <= 1'b0;
    o_wr   <= ~w;
    o_addr <= ~a;
  endtask : cyc
endmodule : emm_cpu_model

`default_nettype wire

// file: emm_mapper.sv
// Purpose: address range memory mapper of an in-circuit emulator
// Assumes: memory cycle inputs synchronous to i_clk; one cycle per address
// Notes:   cycle outputs lag the address by one clock; table kept as blocks
`default_nettype none

// Behaviour
// - each entry holds exactly one of five descriptors
// - descriptor of the previous clock's address is output every cycle
// - address matching no entry takes the default descriptor
// - range ends widen to whole blocks, covering partly touched ones
// - start inside a block becomes that block's start
// - single address entry maps exactly its own block
// - cycles in target ranges go to the target system
// - writes to emulation ROM leave the stored data unchanged
// - enabled ROM writes are flagged and break execution
// - any access to a guarded range breaks execution
// - emulation memory mapped as ROM acts read-only
// - RAM ranges accept reads and writes freely
// - default may only be target RAM, target ROM or guarded
// - with no default chosen, unmapped blocks are guarded
// - emulation entries reduce available blocks by their size
// - target entries leave available blocks unchanged
// - range addresses are up to 32 bits wide
// - one entry or all entries can be removed
// - ending configuration with an empty map is an error
module emm_mapper
  import emm_pkg::*;
#(
  parameter int NENT       = EMM_NUM_ENT,
  parameter int SH         = EMM_BLK_SHIFT,
  parameter int EMU_BLOCKS = EMM_EMU_BLOCKS
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  // register port
  input  wire logic [3:0]            i_reg_addr,
  input  wire logic [31:0]           i_reg_wdata,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  output logic      [31:0]           o_reg_rdata,
  // processor memory cycle
  input  wire logic [EMM_ADDR_W-1:0] i_addr,
  input  wire logic                  i_cyc,
  input  wire logic                  i_wr,
  // mapper answer
  output emm_desc_t                  o_desc,
  output logic                       o_tgt_sel,
  output logic                       o_emu_sel,
  output logic                       o_emu_wr_en,
  output logic                       o_rom_wr_err,
  output logic                       o_break,
  output logic                       o_cfg_done
);

  localparam int AW = EMM_ADDR_W;
  localparam int BW = AW - SH;
  localparam int IW = (NENT > 1) ? $clog2(NENT) : 1;
  localparam int CW = BW + IW + 1;

  // configuration registers
  logic            rombrk_reg;
  emm_desc_t       dflt_reg;
  logic [IW-1:0]   idx_reg;
  logic [AW-1:0]   start_reg;
  logic [AW-1:0]   end_reg;
  emm_desc_t       edesc_reg;
  logic            single_reg;

  // entry table
  logic [NENT-1:0] valid_reg;
  logic [BW-1:0]   first_reg [NENT];
  logic [BW-1:0]   last_reg  [NENT];
  emm_desc_t       desc_reg  [NENT];

  // status
  logic            done_reg;
  logic            end_err_reg;
  logic            add_err_reg;
  logic            dflt_err_reg;
  logic            rom_seen_reg;
  logic            guard_seen_reg;

  // bus decode
  logic            wr_ctrl;
  logic            wr_dflt;
  logic            wr_index;
  logic            wr_start;
  logic            wr_end;
  logic            wr_ecfg;
  logic            wr_cmd;
  logic            wr_status;
  logic            cmd_add;
  logic            cmd_del_one;
  logic            cmd_del_all;
  logic            cmd_end;
  emm_desc_t       wdesc;

  // entry add computation
  logic [BW-1:0]   add_first;
  logic [BW-1:0]   add_last;
  logic [CW-1:0]   add_span;
  logic [CW-1:0]   old_span;
  logic [CW-1:0]   used;
  logic [CW-1:0]   avail;
  logic            idx_ok;
  logic            desc_ok;
  logic            add_ok;

  // lookup
  logic            hit;
  emm_desc_t       hit_desc;
  emm_desc_t       eff_desc;
  logic            rom_wr;
  logic            guard_acc;

  emm_tab_if #(.NENT(NENT), .BW(BW)) tab ();

  always_comb begin
    tab.valid = valid_reg;
    for (int i = 0; i < NENT; i++) begin
      tab.first_blk[i] = first_reg[i];
      tab.last_blk[i]  = last_reg[i];
      tab.desc[i]      = desc_reg[i];
    end
  end

  emm_range_match #(.NENT(NENT), .BW(BW)) u_match (
    .tab    (tab),
    .i_blk  (i_addr[AW-1:SH]),
    .o_hit  (hit),
    .o_desc (hit_desc)
  );

  emm_block_count #(.NENT(NENT), .BW(BW), .CW(CW)) u_count (
    .tab    (tab),
    .o_used (used)
  );

  // ---- register write decode
  assign wr_ctrl   = i_reg_wr && (i_reg_addr == EMM_OFS_CTRL);
  assign wr_dflt   = i_reg_wr && (i_reg_addr == EMM_OFS_DFLT);
  assign wr_index  = i_reg_wr && (i_reg_addr == EMM_OFS_INDEX);
  assign wr_start  = i_reg_wr && (i_reg_addr == EMM_OFS_START);
  assign wr_end    = i_reg_wr && (i_reg_addr == EMM_OFS_END);
  assign wr_ecfg   = i_reg_wr && (i_reg_addr == EMM_OFS_ECFG);
  assign wr_cmd    = i_reg_wr && (i_reg_addr == EMM_OFS_CMD);
  assign wr_status = i_reg_wr && (i_reg_addr == EMM_OFS_STATUS);

  assign cmd_add     = wr_cmd && i_reg_wdata[EMM_CMD_ADD];
  assign cmd_del_one = wr_cmd && i_reg_wdata[EMM_CMD_DEL_ONE];
  assign cmd_del_all = wr_cmd && i_reg_wdata[EMM_CMD_DEL_ALL];
  assign cmd_end     = wr_cmd && i_reg_wdata[EMM_CMD_END];

  assign wdesc = emm_desc_t'(i_reg_wdata[2:0]);

  // ---- entry add: block rounding and space check
  assign add_first = start_reg[AW-1:SH];
  assign add_last  = single_reg ? add_first : end_reg[AW-1:SH];
  assign add_span  = CW'(add_last) - CW'(add_first) + CW'(1);
  assign avail     = CW'(EMU_BLOCKS) - used;
  assign idx_ok    = 32'(idx_reg) < NENT;

  always_comb begin
    old_span = '0;
    if (idx_ok && valid_reg[idx_reg] && emm_is_emu(desc_reg[idx_reg])) begin
      old_span = CW'(last_reg[idx_reg]) - CW'(first_reg[idx_reg]) + CW'(1);
    end
  end

  assign desc_ok = edesc_reg <= EMM_GUARD;

  always_comb begin
    add_ok = idx_ok && desc_ok && (add_last >= add_first);
    // emulation entries must fit in what is left
    if (emm_is_emu(edesc_reg) && (add_span > avail + old_span)) begin
      add_ok = 1'b0;
    end
  end

  // ---- configuration registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rombrk_reg <= EMM_CTRL_RST;
    end else if (wr_ctrl) begin
      rombrk_reg <= i_reg_wdata[EMM_CTRL_ROMBRK];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dflt_reg <= EMM_DFLT_RST;
    end else if (wr_dflt) begin
      // emulation descriptors refused as default
      if ((wdesc == EMM_TGT_RAM) || (wdesc == EMM_TGT_ROM) || (wdesc == EMM_GUARD)) begin
        dflt_reg <= wdesc;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      idx_reg    <= '0;
      start_reg  <= '0;
      end_reg    <= '0;
      edesc_reg  <= EMM_DFLT_RST;
      single_reg <= 1'b0;
    end else begin
      if (wr_index) begin
        idx_reg <= i_reg_wdata[IW-1:0];
      end
      if (wr_start) begin
        start_reg <= i_reg_wdata[AW-1:0];
      end
      if (wr_end) begin
        end_reg <= i_reg_wdata[AW-1:0];
      end
      if (wr_ecfg) begin
        edesc_reg  <= wdesc;
        single_reg <= i_reg_wdata[EMM_ECFG_SINGLE];
      end
    end
  end

  // ---- entry table
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      valid_reg <= '0;
      for (int i = 0; i < NENT; i++) begin
        first_reg[i] <= '0;
        last_reg[i]  <= '0;
        desc_reg[i]  <= EMM_GUARD;
      end
    end else if (cmd_del_all) begin
      valid_reg <= '0;
    end else if (cmd_del_one) begin
      if (idx_ok) begin
        valid_reg[idx_reg] <= 1'b0;
      end
    end else if (cmd_add && add_ok) begin
      valid_reg[idx_reg] <= 1'b1;
      first_reg[idx_reg] <= add_first;
      last_reg[idx_reg]  <= add_last;
      desc_reg[idx_reg]  <= edesc_reg;
    end
  end

  // ---- session state and sticky status
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      done_reg <= 1'b0;
    end else if (cmd_del_all || cmd_del_one || cmd_add) begin
      done_reg <= 1'b0;
    end else if (cmd_end) begin
      done_reg <= |valid_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      end_err_reg  <= 1'b0;
      add_err_reg  <= 1'b0;
      dflt_err_reg <= 1'b0;
    end else begin
      // a new error wins over a clear in the same cycle
      if (cmd_end && !(cmd_del_all || cmd_del_one || cmd_add) && (valid_reg == '0)) begin
        end_err_reg <= 1'b1;
      end else if (wr_status && i_reg_wdata[EMM_ST_END_ERR]) begin
        end_err_reg <= 1'b0;
      end
      if (cmd_add && !cmd_del_all && !cmd_del_one && !add_ok) begin
        add_err_reg <= 1'b1;
      end else if (wr_status && i_reg_wdata[EMM_ST_ADD_ERR]) begin
        add_err_reg <= 1'b0;
      end
      if (wr_dflt && (wdesc != EMM_TGT_RAM) && (wdesc != EMM_TGT_ROM)
          && (wdesc != EMM_GUARD)) begin
        dflt_err_reg <= 1'b1;
      end else if (wr_status && i_reg_wdata[EMM_ST_DFLT_ERR]) begin
        dflt_err_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rom_seen_reg   <= 1'b0;
      guard_seen_reg <= 1'b0;
    end else begin
      if (rom_wr && rombrk_reg) begin
        rom_seen_reg <= 1'b1;
      end else if (wr_status && i_reg_wdata[EMM_ST_ROM_WR]) begin
        rom_seen_reg <= 1'b0;
      end
      if (guard_acc) begin
        guard_seen_reg <= 1'b1;
      end else if (wr_status && i_reg_wdata[EMM_ST_GUARD]) begin
        guard_seen_reg <= 1'b0;
      end
    end
  end

  // ---- register read, data valid in the following cycle only
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        EMM_OFS_CTRL:   o_reg_rdata <= 32'(rombrk_reg);
        EMM_OFS_DFLT:   o_reg_rdata <= 32'(dflt_reg);
        EMM_OFS_INDEX:  o_reg_rdata <= 32'(idx_reg);
        EMM_OFS_START:  o_reg_rdata <= 32'(start_reg);
        EMM_OFS_END:    o_reg_rdata <= 32'(end_reg);
        EMM_OFS_ECFG:   o_reg_rdata <= 32'({single_reg, edesc_reg});
        EMM_OFS_STATUS: o_reg_rdata <= 32'({guard_seen_reg, rom_seen_reg, dflt_err_reg,
                                            add_err_reg, end_err_reg, done_reg});
        EMM_OFS_AVAIL:  o_reg_rdata <= 32'(avail);
        EMM_OFS_USED:   o_reg_rdata <= 32'(used);
        EMM_OFS_VALID:  o_reg_rdata <= 32'(valid_reg);
        default:        o_reg_rdata <= '0;
      endcase
    end else begin
      o_reg_rdata <= '0;
    end
  end

  // ---- address lookup
  assign eff_desc  = hit ? hit_desc : dflt_reg;
  assign rom_wr    = i_cyc && i_wr && emm_is_rom(eff_desc);
  assign guard_acc = i_cyc && (eff_desc == EMM_GUARD);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_desc <= EMM_DFLT_RST;
    end else begin
      o_desc <= eff_desc;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tgt_sel <= 1'b0;
      o_emu_sel <= 1'b0;
    end else begin
      o_tgt_sel <= i_cyc && ((eff_desc == EMM_TGT_RAM) || (eff_desc == EMM_TGT_ROM));
      o_emu_sel <= i_cyc && emm_is_emu(eff_desc);
    end
  end

  // emulation memory written only when mapped as RAM
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_emu_wr_en <= 1'b0;
    end else begin
      o_emu_wr_en <= i_cyc && i_wr && (eff_desc == EMM_EMU_RAM);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rom_wr_err <= 1'b0;
      o_break      <= 1'b0;
    end else begin
      o_rom_wr_err <= rom_wr && rombrk_reg;
      o_break      <= (rom_wr && rombrk_reg) || guard_acc;
    end
  end

  assign o_cfg_done = done_reg;

endmodule : emm_mapper

`default_nettype wire

// file: emm_mapper_props.sv
// Purpose: concurrent checks on the memory mapper ports
// Assumes: one clock domain, synchronous active high reset
// Notes:   bound to every mapper instance
`default_nettype none

module emm_mapper_props
  import emm_pkg::*;
#(
  parameter int NENT       = EMM_NUM_ENT,
  parameter int SH         = EMM_BLK_SHIFT,
  parameter int EMU_BLOCKS = EMM_EMU_BLOCKS
) (
  input wire logic                  i_clk,
  input wire logic                  i_srst,
  input wire logic [3:0]            i_reg_addr,
  input wire logic                  i_reg_wr,
  input wire logic [EMM_ADDR_W-1:0] i_addr,
  input wire logic                  i_cyc,
  input wire logic                  i_wr,
  input wire emm_desc_t             o_desc,
  input wire logic                  o_tgt_sel,
  input wire logic                  o_emu_sel,
  input wire logic                  o_emu_wr_en,
  input wire logic                  o_rom_wr_err,
  input wire logic                  o_break,
  input wire logic                  o_cfg_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  desc_legal_a: assert property (o_desc inside {[EMM_EMU_RAM:EMM_GUARD]})
    else $error("descriptor code out of range");
  desc_hold_a: assert property (!$past(i_reg_wr) && $stable(i_addr) |=> $stable(o_desc))
    else $error("descriptor moved with address and table unchanged");
  idle_quiet_a: assert property (!i_cyc |=> !(o_tgt_sel || o_emu_sel || o_emu_wr_en || o_break))
    else $error("cycle output without a memory cycle");
  tgt_route_a: assert property (i_cyc |=> o_tgt_sel == (o_desc inside {EMM_TGT_RAM, EMM_TGT_ROM}))
    else $error("target select disagrees with descriptor");
  emu_route_a: assert property (i_cyc |=> o_emu_sel == (o_desc inside {EMM_EMU_RAM, EMM_EMU_ROM}))
    else $error("emulation select disagrees with descriptor");
  emu_write_a: assert property (i_cyc && i_wr |=> o_emu_wr_en == (o_desc == EMM_EMU_RAM))
    else $error("emulation write enable wrong");
  rom_err_a: assert property (o_rom_wr_err |-> $past(i_cyc) && $past(i_wr) && o_desc inside {EMM_EMU_ROM, EMM_TGT_ROM})
    else $error("rom write error without rom write");
  guard_break_a: assert property (i_cyc ##1 o_desc == EMM_GUARD |-> o_break)
    else $error("guarded access did not break");
  break_cause_a: assert property (o_break |-> o_rom_wr_err || (o_desc == EMM_GUARD && $past(i_cyc)))
    else $error("break without cause");
  done_cause_a: assert property ($rose(o_cfg_done) |-> $past(i_reg_wr) && $past(i_reg_addr) == EMM_OFS_CMD)
    else $error("configuration done without end command");

  cover property (o_rom_wr_err);
  cover property (o_break && o_desc == EMM_GUARD);
  cover property (o_emu_wr_en);
  cover property ($rose(o_cfg_done));
endmodule : emm_mapper_props

bind emm_mapper emm_mapper_props #(.NENT(NENT), .SH(SH), .EMU_BLOCKS(EMU_BLOCKS)) emm_mapper_props_i (
  .i_clk, .i_srst, .i_reg_addr, .i_reg_wr, .i_addr, .i_cyc, .i_wr, .o_desc,
  .o_tgt_sel, .o_emu_sel, .o_emu_wr_en, .o_rom_wr_err, .o_break, .o_cfg_done
);

`default_nettype wire

// file: emm_pkg.sv
// Purpose: shared constants and types of the emulation memory mapper
// Assumes: one clock, synchronous reset, register port indexed by word
// Notes:   descriptor codes are internal to the mapper
`default_nettype none

package emm_pkg;

  typedef enum logic [2:0] {
    EMM_EMU_RAM = 3'h0,
    EMM_EMU_ROM = 3'h1,
    EMM_TGT_RAM = 3'h2,
    EMM_TGT_ROM = 3'h3,
    EMM_GUARD   = 3'h4
  } emm_desc_t;

  // documented widths and own defaults for sizes the text leaves open
  localparam int EMM_ADDR_W     = 32;
  localparam int EMM_BLK_SHIFT  = 12;
  localparam int EMM_NUM_ENT    = 8;
  localparam int EMM_EMU_BLOCKS = 32;

  // register word offsets
  localparam logic [3:0] EMM_OFS_CTRL   = 4'h0;
  localparam logic [3:0] EMM_OFS_DFLT   = 4'h1;
  localparam logic [3:0] EMM_OFS_INDEX  = 4'h2;
  localparam logic [3:0] EMM_OFS_START  = 4'h3;
  localparam logic [3:0] EMM_OFS_END    = 4'h4;
  localparam logic [3:0] EMM_OFS_ECFG   = 4'h5;
  localparam logic [3:0] EMM_OFS_CMD    = 4'h6;
  localparam logic [3:0] EMM_OFS_STATUS = 4'h7;
  localparam logic [3:0] EMM_OFS_AVAIL  = 4'h8;
  localparam logic [3:0] EMM_OFS_USED   = 4'h9;
  localparam logic [3:0] EMM_OFS_VALID  = 4'ha;

  // field positions
  localparam int EMM_CTRL_ROMBRK = 0;
  localparam int EMM_ECFG_SINGLE = 3;
  localparam int EMM_CMD_ADD     = 0;
  localparam int EMM_CMD_DEL_ONE = 1;
  localparam int EMM_CMD_DEL_ALL = 2;
  localparam int EMM_CMD_END     = 3;
  localparam int EMM_ST_DONE     = 0;
  localparam int EMM_ST_END_ERR  = 1;
  localparam int EMM_ST_ADD_ERR  = 2;
  localparam int EMM_ST_DFLT_ERR = 3;
  localparam int EMM_ST_ROM_WR   = 4;
  localparam int EMM_ST_GUARD    = 5;

  // reset values
  localparam logic      EMM_CTRL_RST = 1'b0;
  localparam emm_desc_t EMM_DFLT_RST = EMM_GUARD;

  function automatic logic emm_is_emu(input emm_desc_t d);
    emm_is_emu = (d == EMM_EMU_RAM) || (d == EMM_EMU_ROM);
  endfunction : emm_is_emu

  function automatic logic emm_is_rom(input emm_desc_t d);
    emm_is_rom = (d == EMM_EMU_ROM) || (d == EMM_TGT_ROM);
  endfunction : emm_is_rom

endpackage : emm_pkg

`default_nettype wire

// file: emm_range_match.sv
// Purpose: finds the first map entry covering a block number
// Assumes: table entries are inclusive block ranges
// Notes:   purely combinational
`default_nettype none

module emm_range_match
  import emm_pkg::*;
#(
  parameter int NENT = 8,
  parameter int BW   = 20
) (
  emm_tab_if.user                tab,
  input  wire logic [BW-1:0]     i_blk,
  output logic                   o_hit,
  output emm_desc_t              o_desc
);

  logic [NENT-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < NENT; g++) begin : g_cmp
      assign hit[g] = tab.valid[g] && (i_blk >= tab.first_blk[g])
                      && (i_blk <= tab.last_blk[g]);
    end
  endgenerate

  always_comb begin
    o_hit  = 1'b0;
    o_desc = EMM_GUARD;
    for (int i = NENT - 1; i >= 0; i--) begin
      if (hit[i]) begin
        o_hit  = 1'b1;
        o_desc = tab.desc[i];
      end
    end
  end

endmodule : emm_range_match

`default_nettype wire

// file: emm_tab_if.sv
// Purpose: carries the map entry table from its owner to its readers
// Assumes: table held as block numbers, first and last inclusive
// Notes:   combinational view of the owner's registers
`default_nettype none

interface emm_tab_if #(
  parameter int NENT = 8,
  parameter int BW   = 20
);
  import emm_pkg::*;

  logic [NENT-1:0] valid;
  logic [BW-1:0]   first_blk [NENT];
  logic [BW-1:0]   last_blk  [NENT];
  emm_desc_t       desc      [NENT];

  modport owner (output valid, first_blk, last_blk, desc);
  modport user  (input  valid, first_blk, last_blk, desc);
endinterface : emm_tab_if

`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench of the memory mapper
// Assumes: strobes and cycles driven right after rising edges
// Notes:   expectations come from a local copy of the map table
`default_nettype none

module tb_top;
  import emm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        i_clk       = 1'b0;
  logic        i_srst      = 1'b1;
  logic [3:0]  i_reg_addr  = 4'h0;
  logic [31:0] i_reg_wdata = 32'h0;
  logic        i_reg_wr    = 1'b0;
  logic        i_reg_rd    = 1'b0;
  logic [31:0] o_reg_rdata;
  logic [31:0] i_addr;
  logic        i_cyc;
  logic        i_wr;
  emm_desc_t   o_desc;
  logic        o_tgt_sel;
  logic        o_emu_sel;
  logic        o_emu_wr_en;
  logic        o_rom_wr_err;
  logic        o_break;
  logic        o_cfg_done;
  int          num_errors      = 0;
  int          samples_checked = 0;
  int          seed            = 27;
  logic [19:0] tf [8];
  logic [19:0] tl [8];
  emm_desc_t   td [8];
  logic [7:0]  tv   = 8'h0;
  emm_desc_t   dflt = EMM_GUARD;
  logic        ctrl = 1'b0;
  logic [31:0] r;
  logic [31:0] corner [6] = '{32'h0001_0000, 32'h0001_2fff, 32'h0003_1000,
                              32'h0003_0000, 32'hffff_ffff, 32'h0000_ffff};

  emm_mapper emm_mapper_i (.i_clk, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .i_addr, .i_cyc, .i_wr, .o_desc, .o_tgt_sel, .o_emu_sel, .o_emu_wr_en,
    .o_rom_wr_err, .o_break, .o_cfg_done);
  emm_cpu_model emm_cpu_model_i (.i_clk, .o_addr(i_addr), .o_cyc(i_cyc), .o_wr(i_wr));

  initial begin
    forever #2 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clk);
    i_reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clk);
    i_reg_rd   <= 1'b0;
    #1;
    chk(o_reg_rdata, exp);
  endtask : rd_chk

  function automatic emm_desc_t exp_desc(input logic [31:0] a);
    exp_desc = dflt;
    for (int k = 7; k >= 0; k--) begin
      if (tv[k] && a[31:12] >= tf[k] && a[31:12] <= tl[k]) begin
        exp_desc = td[k];
      end
    end
  endfunction : exp_desc

  function automatic logic [31:0] avail();
    avail = 32'h20;
    for (int k = 0; k < 8; k++) begin
      if (tv[k] && td[k] inside {EMM_EMU_RAM, EMM_EMU_ROM}) begin
        avail = avail - 32'(tl[k] - tf[k]) - 32'h1;
      end
    end
  endfunction : avail

  task automatic add(input int i, input logic [31:0] s, input logic [31:0] e,
                     input emm_desc_t d, input logic one);
    wr(EMM_OFS_START, s);
    wr(EMM_OFS_END, e);
    wr(EMM_OFS_ECFG, {28'h0, one, d});
    wr(EMM_OFS_INDEX, 32'(i));
    wr(EMM_OFS_CMD, 32'h1);
    tf[i] = s[31:12];
    tl[i] = one ? s[31:12] : e[31:12];
    td[i] = d;
    tv[i] = 1'b1;
    rd_chk(EMM_OFS_AVAIL, avail());
  endtask : add

  task automatic mem(input logic [31:0] a, input logic w);
    emm_desc_t d;
    logic      emu;
    logic      err;
    d   = exp_desc(a);
    emu = d inside {EMM_EMU_RAM, EMM_EMU_ROM};
    err = w && ctrl && d inside {EMM_EMU_ROM, EMM_TGT_ROM};
    emm_cpu_model_i.cyc(a, w);
    #1;
    chk(o_desc, d);
    chk({o_tgt_sel, o_emu_sel, o_emu_wr_en, o_rom_wr_err, o_break},
        {d inside {EMM_TGT_RAM, EMM_TGT_ROM}, emu, w && d == EMM_EMU_RAM, err,
         err || d == EMM_GUARD});
  endtask : mem

  task automatic end_sim();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #100000;
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    rd_chk(EMM_OFS_DFLT, 32'h4);
    rd_chk(EMM_OFS_AVAIL, 32'h20);
    rd_chk(4'hf, 32'h0);
    mem(32'h0000_5000, 1'b0);
    for (int d = 0; d < 8; d++) begin
      wr(EMM_OFS_DFLT, 32'(d));
      if (d inside {2, 3, 4}) begin
        dflt = emm_desc_t'(d);
      end
      rd_chk(EMM_OFS_DFLT, 32'(dflt));
    end
    rd_chk(EMM_OFS_STATUS, 32'h28);
    wr(EMM_OFS_DFLT, 32'h3);
    dflt = EMM_TGT_ROM;
    wr(EMM_OFS_CTRL, 32'h1);
    ctrl = 1'b1;
    add(0, 32'h0001_0123, 32'h0001_2001, EMM_EMU_ROM, 1'b0);
    add(1, 32'h0002_0000, 32'h0002_0fff, EMM_TGT_RAM, 1'b0);
    add(2, 32'h0003_0ff0, 32'hffff_ffff, EMM_GUARD, 1'b1);
    add(3, 32'h0001_2000, 32'h0001_3fff, EMM_EMU_RAM, 1'b0);
    add(5, 32'h0002_1000, 32'h0002_1000, EMM_TGT_ROM, 1'b0);
    add(6, 32'hffff_ffff, 32'h0, EMM_EMU_RAM, 1'b1);
    rd_chk(EMM_OFS_VALID, 32'h6f);
    foreach (corner[k]) begin
      mem(corner[k], 1'b1);
    end
    for (int p = 1; p >= 0; p--) begin
      wr(EMM_OFS_CTRL, 32'(p));
      ctrl = p[0];
      for (int n = 0; n < 150; n++) begin
        r = $random(seed);
        mem({12'h000, 8'h0f + 8'(r[31:13] % 36), r[11:0]}, r[12]);
      end
    end
    wr(EMM_OFS_INDEX, 32'h0);
    wr(EMM_OFS_CMD, 32'h2);
    tv[0] = 1'b0;
    rd_chk(EMM_OFS_AVAIL, avail());
    mem(32'h0001_0000, 1'b1);
    wr(EMM_OFS_CMD, 32'h4);
    tv = 8'h0;
    rd_chk(EMM_OFS_VALID, 32'h0);
    rd_chk(EMM_OFS_AVAIL, 32'h20);
    // emulation range of 49 blocks does not fit in 32
    wr(EMM_OFS_START, 32'h0010_0000);
    wr(EMM_OFS_END, 32'h0013_0000);
    wr(EMM_OFS_ECFG, 32'h0);
    wr(EMM_OFS_CMD, 32'h1);
    rd_chk(EMM_OFS_VALID, 32'h0);
    rd_chk(EMM_OFS_STATUS, 32'h3c);
    wr(EMM_OFS_STATUS, 32'h3e);
    rd_chk(EMM_OFS_STATUS, 32'h0);
    wr(EMM_OFS_CMD, 32'h8);
    rd_chk(EMM_OFS_STATUS, 32'h2);
    chk(o_cfg_done, 32'h0);
    add(0, 32'h0004_0000, 32'h0004_0000, EMM_TGT_RAM, 1'b0);
    wr(EMM_OFS_CMD, 32'h8);
    rd_chk(EMM_OFS_STATUS, 32'h3);
    chk(o_cfg_done, 32'h1);
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
